// ---- dv/icl_host_model.sv ----
// host controller model issuing decoded word commands
// assumes one command per call, answer sampled one edge later
`timescale 1ns/100ps
`default_nettype none
module icl_host_model (
  input wire logic clock,
  output var icl_pkg::icl_cmd_type cmd
);
  initial cmd = '0;
  // one word command held for one edge, then released to scrambled idle
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] d);
    @(posedge clock);
    cmd <= '{1'b1, wr, code, d};
    @(posedge clock);
    cmd <= '{1'b0, ~wr, ~code, ~d};
    #1;
  endtask
endmodule
`default_nettype wire

// ---- dv/icl_limit_reg_props.sv ----
// checker for the input current limit register bank
// assumes it is bound into icl_limit_reg and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module icl_limit_reg_props #(
  parameter int OVLD_DELAY_CYC = icl_pkg::ICL_OVLD_DELAY_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire icl_pkg::icl_cmd_type cmd,
  input wire logic [15:0] input_current_ma,
  input wire logic fast_overload_threshold,
  input wire logic [15:0] charge_request_ma,
  input wire logic ack_r,
  input wire logic nack_r,
  input wire logic [15:0] rdata_r,
  input wire logic [15:0] limit_ma_r,
  input wire logic [15:0] charge_ma_r,
  input wire logic charging_r,
  input wire logic shutdown_r
);
  logic [15:0] word_r; // expected register contents
  int ovl_r; // consecutive overload cycles
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_hit;
    cmd.valid && cmd.code == icl_pkg::ICL_CMD_SET_LIMIT;
  endsequence
  sequence s_bad_wr;
    s_hit ##0 cmd.write && cmd.data[12:7] == 6'h00;
  endsequence
  // shadow of the stored word, cleared on a rejected write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      word_r <= icl_pkg::ICL_RESET_VALUE;
    else if (cmd.valid && cmd.write && cmd.code == icl_pkg::ICL_CMD_SET_LIMIT)
      word_r <= (cmd.data[12:7] == 6'h00) ? 16'h0000 : cmd.data;
  end
  // length of the current overload
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      ovl_r <= 0;
    else
      ovl_r <= fast_overload_threshold ? ovl_r + 1 : 0;
  end
  a_ack_taken: assert property (s_hit |=> ack_r && !nack_r)
    else $error("command not acknowledged");
  a_nack_other: assert property (cmd.valid && cmd.code != icl_pkg::ICL_CMD_SET_LIMIT
    |=> nack_r && !ack_r) else $error("foreign code not refused");
  a_limit_decode: assert property (
    limit_ma_r == {3'h0, $past(word_r[12:7]), 7'h00}) else $error("limit decode wrong");
  a_clear_stops: assert property (s_bad_wr |=> ##[1:2] !charging_r)
    else $error("charging kept after bad write");
  a_read_back: assert property (s_hit ##0 !cmd.write |=> rdata_r == $past(word_r))
    else $error("read word wrong");
  a_ovld_cut: assert property (
    fast_overload_threshold [*3] |-> charge_ma_r <= (charge_request_ma >> 1))
    else $error("charge not cut on overload");
  a_shut_early: assert property ($rose(shutdown_r) |-> ovl_r >= OVLD_DELAY_CYC)
    else $error("shutdown too early");
  a_shut_late: assert property (ovl_r == OVLD_DELAY_CYC + 5 |-> shutdown_r)
    else $error("shutdown missing");
  a_shut_zero: assert property (shutdown_r [*2] |-> charge_ma_r == 16'h0000)
    else $error("charge during shutdown");
  a_soft_ramp: assert property (
    charging_r |-> charge_ma_r <= $past(charge_ma_r) + 16'h0040) else $error("ramp too fast");
  a_over_limit: assert property (
    input_current_ma > limit_ma_r |=> charge_ma_r <= $past(charge_ma_r))
    else $error("charge rose over limit");
endmodule
bind icl_limit_reg icl_limit_reg_props #(.OVLD_DELAY_CYC(OVLD_DELAY_CYC)) u_props (.*);
`default_nettype wire

// ---- dv/icl_limit_reg_tb_top.sv ----
// self-checking bench for the input current limit register bank
// assumes the host model drives cmd and the checker is bound in
`timescale 1ns/100ps
`default_nettype none
module icl_limit_reg_tb_top;
  localparam int DLY = 20; // short overload wait
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] in_ma = 16'h0000; // measured input current
  logic ovl = 1'b0; // fast overload level
  logic adp = 1'b1; // adapter able to charge
  logic [15:0] req_ma = 16'h03E8; // 1000 mA wanted
  icl_pkg::icl_cmd_type cmd;
  logic ack, nack, chg, shut;
  logic [15:0] rdata, lim, chg_ma, v;
  int fails = 0;
  int n_checks = 0;
  icl_limit_reg #(.OVLD_DELAY_CYC(DLY)) uut (.clock(clock), .nrst(nrst), .cmd(cmd),
    .input_current_ma(in_ma), .fast_overload_threshold(ovl), .adapter_ok(adp),
    .charge_request_ma(req_ma), .ack_r(ack), .nack_r(nack), .rdata_r(rdata),
    .limit_ma_r(lim), .charge_ma_r(chg_ma), .charging_r(chg), .shutdown_r(shut));
  icl_host_model host (.clock(clock), .cmd(cmd));
  initial forever #5 clock = ~clock;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // every weight alone, then full code, unused bits set
  task automatic t_codes();
    logic [15:0] d;
    chk("limit", 16'h1000, lim);
    for (int b = 7; b <= 13; b++) begin
      d = (b == 13) ? 16'hFFFF : (16'hE07F | (16'h0001 << b));
      host.xfer(1'b1, 8'h3F, d);
      chk("ack", 16'h0001, {15'h0000, ack});
      host.xfer(1'b0, 8'h3F, 16'h0000);
      chk("rdata", d, rdata);
      chk("limit", d & 16'h1F80, lim);
    end
  endtask
  // foreign code, then zero code clears and stops
  task automatic t_bad();
    host.xfer(1'b1, 8'h14, 16'h0000);
    chk("nack", 16'h0002, {14'h0000, nack, ack});
    host.xfer(1'b1, 8'h3F, 16'hE07F);
    cyc(2);
    chk("limit", 16'h0000, lim);
    chk("charging", 16'h0000, {15'h0000, chg});
    host.xfer(1'b0, 8'h3F, 16'h0000);
    chk("rdata", 16'h0000, rdata);
    host.xfer(1'b1, 8'h3F, 16'h1000);
    cyc(2);
    chk("charging", 16'h0001, {15'h0000, chg});
  endtask
  // input above limit takes charge down to zero
  task automatic t_limit();
    cyc(1500);
    v = chg_ma;
    chk("ramped", 16'h0001, {15'h0000, v != 16'h0000});
    @(posedge clock);
    in_ma <= 16'h2000;
    cyc(300);
    chk("lowered", 16'h0001, {15'h0000, chg_ma < v});
    cyc(2000);
    chk("floor", 16'h0000, chg_ma);
    @(posedge clock);
    in_ma <= 16'h0000;
  endtask
  // fast overload cut, shutdown, blocked and soft restart
  task automatic t_fast();
    cyc(1500);
    @(posedge clock);
    ovl <= 1'b1;
    cyc(3);
    chk("cut", 16'h0001, {15'h0000, chg_ma <= 16'h01F4});
    cyc(DLY + 4);
    chk("shut", 16'h0001, {15'h0000, shut});
    chk("charge", 16'h0000, chg_ma);
    @(posedge clock);
    adp <= 1'b0;
    ovl <= 1'b0;
    cyc(3);
    chk("blocked", 16'h0000, {15'h0000, chg});
    @(posedge clock);
    adp <= 1'b1;
    cyc(3);
    chk("restart", 16'h0001, {15'h0000, chg});
    chk("soft", 16'h0001, {15'h0000, chg_ma <= 16'h0040});
  endtask
  // mid-run reset brings back the 4096 mA word
  task automatic t_reset();
    host.xfer(1'b1, 8'h3F, 16'h0200);
    @(posedge clock);
    nrst <= 1'b0;
    cyc(2);
    @(posedge clock);
    nrst <= 1'b1;
    cyc(1);
    host.xfer(1'b0, 8'h3F, 16'h0000);
    chk("rdata", 16'h1000, rdata);
    chk("limit", 16'h1000, lim);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    cyc(2);
    t_codes();
    t_bad();
    t_limit();
    t_fast();
    t_reset();
    give_verdict();
  end
  // hang guard, runs well past the longest sequence
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- logic/icl_limit_reg.sv ----
// input current limit register bank with charge throttling
// assumes decoded word commands from an smbus engine and synchronous analog flags
`timescale 1ns/100ps
`default_nettype none
module icl_limit_reg #(
  parameter int OVLD_DELAY_CYC = icl_pkg::ICL_OVLD_DELAY_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire icl_pkg::icl_cmd_type cmd,
  input wire logic [15:0] input_current_ma,
  input wire logic fast_overload_threshold,
  input wire logic adapter_ok,
  input wire logic [15:0] charge_request_ma,
  output logic ack_r,
  output logic nack_r,
  output logic [15:0] rdata_r,
  output logic [15:0] limit_ma_r,
  output logic [15:0] charge_ma_r,
  output logic charging_r,
  output logic shutdown_r
);

  // limit in mA carried by a register word
  function automatic logic [15:0] limit_of(input logic [15:0] word);
    limit_of = {3'h0, word[icl_pkg::ICL_CODE_MSB:icl_pkg::ICL_CODE_LSB], 7'h00};
  endfunction

  // last count of the ramp tick divider
  localparam logic [12:0] RAMP_LAST = 13'(icl_pkg::ICL_RAMP_TICK_CYC - 1);

  logic [15:0] input_limit_setting_r; // the stored word
  logic charge_ok_r; // last write was in range
  icl_pkg::icl_state_type state_r; // charge control state
  icl_pkg::icl_state_type state_nxt;
  logic [12:0] ramp_div_r; // ramp tick divider
  logic ramp_tick; // one-cycle ramp enable
  logic ovld_expired; // overload lasted the full delay
  logic hit; // command addresses this register
  logic [15:0] target_ma; // charge current aimed at
  logic [15:0] charge_ma_nxt;

  // command decode and ramp enable
  assign hit = cmd.valid && (cmd.code == icl_pkg::ICL_CMD_SET_LIMIT);
  assign ramp_tick = (ramp_div_r == RAMP_LAST);

  // register write with range check
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      input_limit_setting_r <= icl_pkg::ICL_RESET_VALUE;
      charge_ok_r <= 1'b1;
    end else if (hit && cmd.write) begin
      // zero code is below 128 mA, 63 codes top out at 8.064 A
      // codes 1 to 3 sit under the advised 512 mA floor yet are kept
      if (limit_of(cmd.data) == 16'h0000) begin
        input_limit_setting_r <= icl_pkg::ICL_CLEARED_VALUE;
        charge_ok_r <= 1'b0;
      end else begin
        input_limit_setting_r <= cmd.data;
        charge_ok_r <= 1'b1;
      end
    end
  end

  // command answer: read data and acknowledge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      nack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      // one-cycle answer pulses
      ack_r <= hit;
      nack_r <= cmd.valid && !hit;
      if (hit && !cmd.write) begin
        rdata_r <= input_limit_setting_r;
      end
    end
  end

  // decoded limit for the regulation loop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      limit_ma_r <= limit_of(icl_pkg::ICL_RESET_VALUE);
    end else begin
      limit_ma_r <= limit_of(input_limit_setting_r);
    end
  end

  // ramp tick divider
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ramp_div_r <= '0;
    end else if (ramp_tick) begin
      ramp_div_r <= '0;
    end else begin
      ramp_div_r <= ramp_div_r + 1'b1;
    end
  end

  // overload persistence timer
  icl_ovld_timer #(
    .DELAY_CYC(OVLD_DELAY_CYC)
  ) u_timer (
    .clock(clock),
    .nrst(nrst),
    .run(state_r == icl_pkg::ICL_ST_OVLD),
    .expired(ovld_expired)
  );

  // next charge control state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      icl_pkg::ICL_ST_STOP: begin
        // charging resumes once the adapter is ok and the last write was in range, or no write since reset
        if (charge_ok_r && adapter_ok) begin
          state_nxt = icl_pkg::ICL_ST_RUN;
        end
      end
      icl_pkg::ICL_ST_RUN: begin
        if (!charge_ok_r || !adapter_ok) begin
          state_nxt = icl_pkg::ICL_ST_STOP;
        end else if (fast_overload_threshold) begin
          state_nxt = icl_pkg::ICL_ST_OVLD;
        end
      end
      icl_pkg::ICL_ST_OVLD: begin
        if (!charge_ok_r || !adapter_ok) begin
          state_nxt = icl_pkg::ICL_ST_STOP;
        end else if (ovld_expired) begin
          state_nxt = icl_pkg::ICL_ST_SHUT;
        end else if (!fast_overload_threshold) begin
          state_nxt = icl_pkg::ICL_ST_RUN;
        end
      end
      icl_pkg::ICL_ST_SHUT: begin
        // restart once overload is gone and the adapter can charge
        if (!charge_ok_r) begin
          state_nxt = icl_pkg::ICL_ST_STOP;
        end else if (adapter_ok && !fast_overload_threshold) begin
          state_nxt = icl_pkg::ICL_ST_RUN;
        end
      end
      default: begin
        state_nxt = icl_pkg::ICL_ST_STOP;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= icl_pkg::ICL_ST_STOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // status flags
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      charging_r <= 1'b0;
      shutdown_r <= 1'b0;
    end else begin
      charging_r <= (state_nxt == icl_pkg::ICL_ST_RUN) || (state_nxt == icl_pkg::ICL_ST_OVLD);
      shutdown_r <= (state_nxt == icl_pkg::ICL_ST_SHUT);
    end
  end

  // charge current target and ramp step
  always_comb begin
    case (state_r)
      icl_pkg::ICL_ST_RUN: target_ma = charge_request_ma;
      icl_pkg::ICL_ST_OVLD: target_ma = {1'b0, charge_request_ma[15:1]};
      default: target_ma = 16'h0000;
    endcase
    charge_ma_nxt = charge_ma_r;
    if ((state_r == icl_pkg::ICL_ST_STOP) || (state_r == icl_pkg::ICL_ST_SHUT)) begin
      charge_ma_nxt = 16'h0000;
    end else if (target_ma < charge_ma_r) begin
      // overload cuts straight to the reduced target
      charge_ma_nxt = target_ma;
    end else if (ramp_tick) begin
      if (input_current_ma > limit_ma_r) begin
        // system load first: back off, floor at zero
        if (charge_ma_r > icl_pkg::ICL_RAMP_STEP_MA) begin
          charge_ma_nxt = charge_ma_r - icl_pkg::ICL_RAMP_STEP_MA;
        end else begin
          charge_ma_nxt = 16'h0000;
        end
      end else if ((target_ma - charge_ma_r) > icl_pkg::ICL_RAMP_STEP_MA) begin
        // soft start climbs one step per tick
        charge_ma_nxt = charge_ma_r + icl_pkg::ICL_RAMP_STEP_MA;
      end else begin
        charge_ma_nxt = target_ma;
      end
    end
  end

  // charge current command
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      charge_ma_r <= 16'h0000;
    end else begin
      charge_ma_r <= charge_ma_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- logic/icl_ovld_timer.sv ----
// fast overload persistence timer
// assumes the overload level is synchronous to clock
`timescale 1ns/100ps
`default_nettype none
module icl_ovld_timer #(
  parameter int DELAY_CYC = icl_pkg::ICL_OVLD_DELAY_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic run,
  output logic expired
);

  // wide enough for the delay count
  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

  logic [CW-1:0] count_r; // cycles spent in overload

  // count while run stays high, restart when it drops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else if (!run) begin
      count_r <= '0;
    end else if (count_r != LAST) begin
      count_r <= count_r + 1'b1;
    end
  end

  // flag once the full delay has run out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (count_r == LAST);
    end
  end

endmodule
`default_nettype wire

// ---- logic/icl_pkg.sv ----
// package for the input current limit register bank
// assumes a 100 MHz system clock and an smbus engine that hands over decoded word commands
package icl_pkg;

  // command code of the word register
  localparam logic [7:0] ICL_CMD_SET_LIMIT = 8'h3F;
  // limit code field position
  localparam int ICL_CODE_LSB = 7;
  localparam int ICL_CODE_MSB = 12;
  localparam int ICL_CODE_W = ICL_CODE_MSB - ICL_CODE_LSB + 1;
  // value after power-on reset: 4096 mA
  localparam logic [15:0] ICL_RESET_VALUE = 16'h1000;
  // empty register after a rejected write
  localparam logic [15:0] ICL_CLEARED_VALUE = 16'h0000;

  // clock rate
  localparam int ICL_CLK_PERIOD_NS = 10;
  // fast overload wait before shutdown
  localparam int ICL_OVLD_DELAY_US = 260;
  localparam int ICL_OVLD_DELAY_CYC = (ICL_OVLD_DELAY_US * 1000) / ICL_CLK_PERIOD_NS;
  // charge ramp tick, also the soft start rate
  localparam int ICL_RAMP_TICK_NS = 1000;
  localparam int ICL_RAMP_TICK_CYC = ICL_RAMP_TICK_NS / ICL_CLK_PERIOD_NS;
  // charge current change per ramp tick, in mA
  localparam logic [15:0] ICL_RAMP_STEP_MA = 16'h0040;

  // one decoded word command from the serial engine
  typedef struct packed {
    logic valid;       // one-cycle strobe
    logic write;       // 1 = word write, 0 = word read
    logic [7:0] code;  // command code
    logic [15:0] data; // write word
  } icl_cmd_type;

  // charge control states
  typedef enum logic [1:0] {
    ICL_ST_STOP = 2'b00,
    ICL_ST_RUN = 2'b01,
    ICL_ST_OVLD = 2'b10,
    ICL_ST_SHUT = 2'b11
  } icl_state_type;

endpackage
